// >>> shared/isc_pkg.sv
// Package with register map, field positions and event carrier of the interrupt status collector.
package isc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map.
  localparam int ISC_ADDR_W = 8;
  localparam logic [ISC_ADDR_W-1:0] ISC_OFF_STATUS = 8'h58;
  localparam logic [ISC_ADDR_W-1:0] ISC_OFF_MASK = 8'h5c;
  localparam logic [ISC_ADDR_W-1:0] ISC_OFF_IO_CFG = 8'h60;
  localparam logic [ISC_ADDR_W-1:0] ISC_OFF_BYTE_TEST = 8'h64;

  ////////////////////////////////////////////////////////////////////////////
  // Status bit positions.
  localparam int ISC_B_SW = 31;
  localparam int ISC_B_TX_HALT = 25;
  localparam int ISC_B_RX_HALT = 24;
  localparam int ISC_B_DROP_MID = 23;
  localparam int ISC_B_TX_DONE = 21;
  localparam int ISC_B_RX_DMA = 20;
  localparam int ISC_B_TIMER = 19;
  localparam int ISC_B_XCVR = 18;
  localparam int ISC_B_WAKE = 17;
  localparam int ISC_B_TSF_OVF = 16;
  localparam int ISC_B_OVERSIZE = 15;
  localparam int ISC_B_RX_ERR = 14;
  localparam int ISC_B_TX_ERR = 13;
  localparam int ISC_B_TDF_UNDER = 11;
  localparam int ISC_B_TDF_OVER = 10;
  localparam int ISC_B_TDF_SPACE = 9;
  localparam int ISC_B_TSF_FULL = 8;
  localparam int ISC_B_TSF_LEVEL = 7;
  localparam int ISC_B_DROPPED = 6;
  localparam int ISC_B_RDF_LEVEL = 5;
  localparam int ISC_B_RSF_FULL = 4;
  localparam int ISC_B_RSF_LEVEL = 3;
  localparam int ISC_B_IO_LSB = 0;
  localparam int ISC_IO_PINS = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Field masks, reset values and event thresholds.
  localparam logic [31:0] ISC_IMPL_MASK = 32'h83bf_efff;
  localparam logic [31:0] ISC_W1C_MASK = 32'h83bb_efff;
  localparam logic [31:0] ISC_STATUS_RST = 32'h0000_0000;
  localparam logic [31:0] ISC_MASK_RST = 32'h0000_0000;
  localparam logic [2:0] ISC_IO_CFG_RST = 3'h0;
  localparam logic [31:0] ISC_BYTE_TEST_VAL = 32'h8765_4321;
  localparam logic [31:0] ISC_DROP_BEFORE_MID = 32'h7fff_ffff;
  localparam logic [31:0] ISC_DROP_MID = 32'h8000_0000;
  localparam logic [15:0] ISC_TIMER_ZERO = 16'h0000;
  localparam logic [15:0] ISC_TIMER_WRAP = 16'hffff;
  localparam int ISC_LEN_W = 14;
  localparam logic [ISC_LEN_W-1:0] ISC_OVERSIZE_LEN = 14'h0800;
  localparam int ISC_LVL_N = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Event and condition inputs from the engines, all on the device clock.
  typedef struct packed {
    logic tx_stop_req;
    logic tx_halted;
    logic rx_halted;
    logic tx_buf_loaded;
    logic completion_notify_marker;
    logic rx_dma_done;
    logic transceiver_event;
    logic wake_event;
    logic tsf_push;
    logic tsf_full;
    logic rx_frame_end;
    logic rx_error;
    logic tx_error;
    logic tdf_underrun;
    logic tdf_write;
    logic tdf_full;
    logic tsf_level_hit;
    logic rdf_level_hit;
    logic rsf_full;
    logic rsf_level_hit;
    logic frame_dropped;
  } isc_evt_t;

endpackage

// >>> verilog/isc_collector.sv
// Interrupt status collector with its APB register slave.
`timescale 1ns/10ps
// What this block does
// - Writing one clears a clearable status bit; writing zero leaves it.
// - Software flag bit 31 is set while software enable is high.
// - Bit 25 sets when stop transmit is requested and transmitter has halted.
// - Bit 24 sets when the receive engine halts.
// - Bit 23 sets when drop counter steps from 7fffffff to 80000000.
// - Bit 21 sets when a marked transmit buffer finishes loading.
// - Bit 20 sets when the programmed receive DMA amount has moved.
// - Bit 19 sets when the timer wraps from zero to ffff.
// - Bit 18 is read only and mirrors the transceiver event.
// - Bit 17 sets on wake events regardless of wake output; one clears.
// - Wake interrupt is flag bit 17 gated by its enable bit, with no delay.
// - Bit 16 sets on a push into a full transmit status FIFO.
// - Bit 15 sets when a received packet exceeds 2048 bytes.
// - Bit 14 flags receive errors, bit 13 transmit errors.
// - Bit 11 sets on transmit data FIFO underrun.
// - Bit 10 sets on a write into a full transmit data FIFO.
// - Bit 9 sets when transmit free space exceeds the programmed level.
// - Bit 8 sets on transmit status full, bit 4 on receive status full.
// - Bits 7, 5 and 3 set when their FIFO reaches its level.
// - Bit 6 sets whenever an incoming frame is dropped.
// - Bits 2-0 latch I/O pin events per pin configuration; one clears.
// - Flags other than bit 31 record events whatever the enable mask holds.
// - Master interrupt is high while any enabled flag is active.
module isc_collector
  import isc_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ISC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Engine events and conditions.
  input wire isc_evt_t evt,
  input wire logic [31:0] drop_count,
  input wire logic [15:0] timer_count,
  input wire logic [ISC_LEN_W-1:0] rx_frame_len,
  input wire logic [7:0] tx_free_space,
  input wire logic [7:0] tx_space_level,
  input wire logic enter_low_power,
  // Pins.
  input wire logic [ISC_IO_PINS-1:0] io_pins,
  // Interrupt and power outputs.
  output logic irq_master,
  output logic wake_irq,
  output logic low_power,
  output logic software_event_enable
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state.
  logic [31:0] sts_q, sts_d;
  logic [31:0] mask_q, mask_d;
  logic [ISC_IO_PINS-1:0] io_cfg_q, io_cfg_d;
  logic [31:0] prdata_q, prdata_d;
  logic low_power_q, low_power_d;
  logic [ISC_LVL_N-1:0] lvl_q, lvl_d;
  logic drop_at_max_q, drop_at_max_d;
  logic timer_at_zero_q, timer_at_zero_d;
  logic [ISC_IO_PINS-1:0] io_meta_q, io_sync_q, io_prev_q;

  logic setup_ph;
  logic wr_acc;
  logic wr_sts;
  logic wr_mask;
  logic wr_io_cfg;
  logic wr_byte_test;
  logic mapped;
  logic [31:0] set_vec;
  logic [31:0] clr_vec;
  logic [ISC_LVL_N-1:0] lvl_now;
  logic [ISC_LVL_N-1:0] lvl_rise;
  logic [ISC_IO_PINS-1:0] io_rise;
  logic [ISC_IO_PINS-1:0] io_fall;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode.
  assign setup_ph = psel && !penable;
  assign wr_acc = psel && penable && pwrite;
  assign mapped = (paddr == ISC_OFF_STATUS) || (paddr == ISC_OFF_MASK) ||
                  (paddr == ISC_OFF_IO_CFG) || (paddr == ISC_OFF_BYTE_TEST);
  assign wr_sts = wr_acc && (paddr == ISC_OFF_STATUS);
  assign wr_mask = wr_acc && (paddr == ISC_OFF_MASK);
  assign wr_io_cfg = wr_acc && (paddr == ISC_OFF_IO_CFG);
  assign wr_byte_test = wr_acc && (paddr == ISC_OFF_BYTE_TEST);

  // The slave never inserts wait states.
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = prdata_q;

  // Read data is captured in the setup phase so the access phase sees flops.
  always_comb begin
    prdata_d = prdata_q;
    if (setup_ph) begin
      unique case (paddr)
        ISC_OFF_STATUS: prdata_d = sts_q;
        ISC_OFF_MASK: prdata_d = mask_q;
        ISC_OFF_IO_CFG: prdata_d = {29'h0000_0000, io_cfg_q};
        ISC_OFF_BYTE_TEST: prdata_d = ISC_BYTE_TEST_VAL;
        default: prdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prdata_q <= 32'h0000_0000;
    end else begin
      prdata_q <= prdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser; the second stage and its delayed copy feed the edge logic.
  always_ff @(posedge clk) begin
    if (rst) begin
      io_meta_q <= 3'h0;
      io_sync_q <= 3'h0;
      io_prev_q <= 3'h0;
    end else begin
      io_meta_q <= io_pins;
      io_sync_q <= io_meta_q;
      io_prev_q <= io_sync_q;
    end
  end

  assign io_rise = io_sync_q & ~io_prev_q;
  assign io_fall = ~io_sync_q & io_prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // Level conditions whose rising edge sets a flag.
  always_comb begin
    lvl_now = '0;
    lvl_now[0] = evt.tx_stop_req && evt.tx_halted;
    lvl_now[1] = evt.rx_halted;
    lvl_now[2] = tx_free_space > tx_space_level;
    lvl_now[3] = evt.tsf_full;
    lvl_now[4] = evt.rsf_full;
    lvl_now[5] = evt.tsf_level_hit;
    lvl_now[6] = evt.rdf_level_hit;
    lvl_now[7] = evt.rsf_level_hit;
  end

  assign lvl_rise = lvl_now & ~lvl_q;
  assign lvl_d = lvl_now;
  assign drop_at_max_d = drop_count == ISC_DROP_BEFORE_MID;
  assign timer_at_zero_d = timer_count == ISC_TIMER_ZERO;

  always_ff @(posedge clk) begin
    if (rst) begin
      lvl_q <= '0;
      drop_at_max_q <= 1'b0;
      timer_at_zero_q <= 1'b0;
    end else begin
      lvl_q <= lvl_d;
      drop_at_max_q <= drop_at_max_d;
      timer_at_zero_q <= timer_at_zero_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Set vector, independent of the enable mask except software flag bit 31.
  // mask consulted for bit 31 only
  always_comb begin
    set_vec = 32'h0000_0000;
    set_vec[ISC_B_SW] = mask_q[ISC_B_SW];
    set_vec[ISC_B_TX_HALT] = lvl_rise[0];
    set_vec[ISC_B_RX_HALT] = lvl_rise[1];
    set_vec[ISC_B_DROP_MID] = drop_at_max_q && (drop_count == ISC_DROP_MID);
    set_vec[ISC_B_TX_DONE] = evt.tx_buf_loaded && evt.completion_notify_marker;
    set_vec[ISC_B_RX_DMA] = evt.rx_dma_done;
    set_vec[ISC_B_TIMER] = timer_at_zero_q && (timer_count == ISC_TIMER_WRAP);
    set_vec[ISC_B_WAKE] = evt.wake_event;
    set_vec[ISC_B_TSF_OVF] = evt.tsf_push && evt.tsf_full;
    set_vec[ISC_B_OVERSIZE] = evt.rx_frame_end && (rx_frame_len > ISC_OVERSIZE_LEN);
    set_vec[ISC_B_RX_ERR] = evt.rx_error;
    set_vec[ISC_B_TX_ERR] = evt.tx_error;
    set_vec[ISC_B_TDF_UNDER] = evt.tdf_underrun;
    set_vec[ISC_B_TDF_OVER] = evt.tdf_write && evt.tdf_full;
    set_vec[ISC_B_TDF_SPACE] = lvl_rise[2];
    set_vec[ISC_B_TSF_FULL] = lvl_rise[3];
    set_vec[ISC_B_RSF_FULL] = lvl_rise[4];
    set_vec[ISC_B_TSF_LEVEL] = lvl_rise[5];
    set_vec[ISC_B_RDF_LEVEL] = lvl_rise[6];
    set_vec[ISC_B_RSF_LEVEL] = lvl_rise[7];
    set_vec[ISC_B_DROPPED] = evt.frame_dropped;
    // pin events, rising edge when the config bit is one, falling otherwise
    set_vec[ISC_B_IO_LSB +: ISC_IO_PINS] = (io_cfg_q & io_rise) | (~io_cfg_q & io_fall);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status, mask and configuration registers.
  // write one clears
  assign clr_vec = wr_sts ? (pwdata & ISC_W1C_MASK) : 32'h0000_0000;

  always_comb begin
    sts_d = (sts_q & ~clr_vec) | set_vec;
    sts_d[ISC_B_XCVR] = evt.transceiver_event;
    sts_d = sts_d & ISC_IMPL_MASK;
    mask_d = wr_mask ? (pwdata & ISC_IMPL_MASK) : mask_q;
    io_cfg_d = wr_io_cfg ? pwdata[ISC_IO_PINS-1:0] : io_cfg_q;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sts_q <= ISC_STATUS_RST;
      mask_q <= ISC_MASK_RST;
      io_cfg_q <= ISC_IO_CFG_RST;
    end else begin
      sts_q <= sts_d;
      mask_q <= mask_d;
      io_cfg_q <= io_cfg_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Low power state.
  always_comb begin
    low_power_d = low_power_q;
    if (enter_low_power) begin
      low_power_d = 1'b1;
    end
    if (wr_byte_test) begin
      low_power_d = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      low_power_q <= 1'b0;
    end else begin
      low_power_q <= low_power_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.
  // enabled flag active
  assign irq_master = |(sts_q & mask_q);
  assign wake_irq = sts_q[ISC_B_WAKE] && mask_q[ISC_B_WAKE];
  assign low_power = low_power_q;
  assign software_event_enable = mask_q[ISC_B_SW];

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.
  logic [31:0] clr_only;
  assign clr_only = clr_vec & ~set_vec;

  AST_W1C_CLEAR: assert property (@(posedge clk) disable iff (rst)
    wr_sts |=> ((sts_q & $past(clr_only) & ISC_W1C_MASK) == 32'h0000_0000))
    else $error("status bit written with one did not clear");

  AST_W0_HOLDS: assert property (@(posedge clk) disable iff (rst)
    (wr_sts && !pwdata[ISC_B_TX_DONE] && sts_q[ISC_B_TX_DONE]) |=> sts_q[ISC_B_TX_DONE])
    else $error("status bit written with zero changed");

  AST_SW_SET: assert property (@(posedge clk) disable iff (rst)
    mask_q[ISC_B_SW] |=> sts_q[ISC_B_SW])
    else $error("software flag not set while enabled");

  AST_TX_HALT: assert property (@(posedge clk) disable iff (rst)
    (evt.tx_stop_req && evt.tx_halted && !lvl_q[0]) |=> sts_q[ISC_B_TX_HALT])
    else $error("transmit halted flag missing");

  AST_DROP_MID: assert property (@(posedge clk) disable iff (rst)
    (drop_count == ISC_DROP_BEFORE_MID) ##1 (drop_count == ISC_DROP_MID) |=> sts_q[ISC_B_DROP_MID])
    else $error("drop counter midpoint flag missing");

  AST_TIMER_WRAP: assert property (@(posedge clk) disable iff (rst)
    (timer_count == ISC_TIMER_ZERO) ##1 (timer_count == ISC_TIMER_WRAP) |=> sts_q[ISC_B_TIMER])
    else $error("timer wrap flag missing");

  AST_XCVR_MIRROR: assert property (@(posedge clk) disable iff (rst)
    $past(!rst) |-> (sts_q[ISC_B_XCVR] == $past(evt.transceiver_event)))
    else $error("transceiver bit does not follow its source");

  AST_WAKE_KEEPS_SLEEP: assert property (@(posedge clk) disable iff (rst)
    (low_power_q && evt.wake_event && !wr_byte_test) |=> low_power_q)
    else $error("wake event left low power");

  AST_BYTE_TEST_WAKES: assert property (@(posedge clk) disable iff (rst)
    (low_power_q && wr_byte_test) |=> (!low_power_q && sts_q[ISC_B_XCVR] == $past(evt.transceiver_event)))
    else $error("byte test write did not leave low power");

  AST_WAKE_IRQ: assert property (@(posedge clk) disable iff (rst)
    (evt.wake_event && mask_q[ISC_B_WAKE] && !wr_mask) |=> wake_irq && irq_master)
    else $error("wake interrupt delayed");

  AST_OVERSIZE: assert property (@(posedge clk) disable iff (rst)
    (evt.rx_frame_end && rx_frame_len == 14'h0801) |=> sts_q[ISC_B_OVERSIZE])
    else $error("oversize flag missing");

  AST_NOT_OVERSIZE: assert property (@(posedge clk) disable iff (rst)
    (!sts_q[ISC_B_OVERSIZE] && evt.rx_frame_end && rx_frame_len == ISC_OVERSIZE_LEN) |=> !sts_q[ISC_B_OVERSIZE])
    else $error("oversize flag set at exactly the limit");

  AST_MASK_FREE: assert property (@(posedge clk) disable iff (rst)
    (evt.rx_error && !mask_q[ISC_B_RX_ERR] && !wr_mask) |=> (sts_q[ISC_B_RX_ERR] && !mask_q[ISC_B_RX_ERR]))
    else $error("masked source not recorded");

  AST_IRQ_ENABLED: assert property (@(posedge clk) disable iff (rst)
    (sts_q[ISC_B_RX_ERR] && mask_q[ISC_B_RX_ERR]) |-> irq_master)
    else $error("master interrupt low with an enabled flag");

  AST_SET_WINS: assert property (@(posedge clk) disable iff (rst)
    (evt.frame_dropped && wr_sts && pwdata[ISC_B_DROPPED]) |=> sts_q[ISC_B_DROPPED])
    else $error("event lost under clear");

  AST_RESERVED_ZERO: assert property (@(posedge clk) disable iff (rst)
    ((sts_q | mask_q) & ~ISC_IMPL_MASK) == 32'h0000_0000)
    else $error("reserved bit set");

  AST_PIN_EVENT: assert property (@(posedge clk) disable iff (rst)
    (io_cfg_q[1] && io_rise[1]) |=> sts_q[ISC_B_IO_LSB + 1])
    else $error("pin event not latched");

  AST_PIN_FALL: assert property (@(posedge clk) disable iff (rst)
    (!io_cfg_q[0] && io_fall[0]) |=> sts_q[ISC_B_IO_LSB])
    else $error("falling pin event not latched");

  AST_RX_HALT: assert property (@(posedge clk) disable iff (rst)
    (evt.rx_halted && !lvl_q[1]) |=> sts_q[ISC_B_RX_HALT])
    else $error("receive halted flag missing");

  AST_TX_DONE: assert property (@(posedge clk) disable iff (rst)
    (evt.tx_buf_loaded && evt.completion_notify_marker) |=> sts_q[ISC_B_TX_DONE])
    else $error("transmit buffer done flag missing");

  AST_TSF_OVF: assert property (@(posedge clk) disable iff (rst)
    (evt.tsf_push && evt.tsf_full) |=> sts_q[ISC_B_TSF_OVF])
    else $error("transmit status overflow flag missing");

  AST_TDF_OVER: assert property (@(posedge clk) disable iff (rst)
    (evt.tdf_write && evt.tdf_full) |=> sts_q[ISC_B_TDF_OVER])
    else $error("transmit data overrun flag missing");

  AST_SPACE: assert property (@(posedge clk) disable iff (rst)
    ((tx_free_space > tx_space_level) && !lvl_q[2]) |=> sts_q[ISC_B_TDF_SPACE])
    else $error("transmit space flag missing");

  AST_DROPPED: assert property (@(posedge clk) disable iff (rst)
    evt.frame_dropped |=> sts_q[ISC_B_DROPPED])
    else $error("frame dropped flag missing");

endmodule

// >>> test/tb_top.sv
// Self-checking testbench of the interrupt status collector over APB.
`timescale 1ns/10ps
module tb_top
  import isc_pkg::*;
;
  ////////////////////////////////////////////////////////////////////////////
  // Signals and event table.
  logic clk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic enter_low_power, irq_master, wake_irq, low_power, software_event_enable;
  logic [ISC_ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, drop_count, rd;
  logic [15:0] timer_count;
  logic [ISC_LEN_W-1:0] rx_frame_len;
  logic [7:0] tx_free_space, tx_space_level;
  logic [ISC_IO_PINS-1:0] io_pins;
  isc_evt_t evt;
  int failures = 0;
  int cmp_count = 0;
  int cycles = 0;
  // Each event vector is pulsed once; the paired word is the status it must leave.
  localparam logic [20:0] EV [19] = '{21'h180000, 21'h080000, 21'h040000, 21'h030000, 21'h020000,
    21'h008000, 21'h002000, 21'h001800, 21'h000400, 21'h000200, 21'h000100, 21'h000080, 21'h000060,
    21'h000040, 21'h000010, 21'h000008, 21'h000004, 21'h000002, 21'h000001};
  localparam logic [31:0] EX [19] = '{32'h0200_0000, 32'h0, 32'h0100_0000, 32'h0020_0000, 32'h0,
    32'h0010_0000, 32'h0002_0000, 32'h0001_0100, 32'h0000_8000, 32'h0000_4000, 32'h0000_2000,
    32'h0000_0800, 32'h0000_0400, 32'h0, 32'h0000_0080, 32'h0000_0020, 32'h0000_0010, 32'h0000_0008,
    32'h0000_0040};

  isc_collector uut (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .evt(evt),
    .drop_count(drop_count), .timer_count(timer_count), .rx_frame_len(rx_frame_len),
    .tx_free_space(tx_free_space), .tx_space_level(tx_space_level), .enter_low_power(enter_low_power),
    .io_pins(io_pins), .irq_master(irq_master), .wake_irq(wake_irq), .low_power(low_power),
    .software_event_enable(software_event_enable)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Clock, timeout and verdict.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("Mismatches %0d, comparisons %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // APB master; a non-zero side vector is held on evt during the access phase.
  task automatic apb(input logic wr, input logic [ISC_ADDR_W-1:0] a, input logic [31:0] d,
                     input logic [20:0] side);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    if (side != 21'h0) begin
      evt <= isc_evt_t'(side);
    end
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (side != 21'h0) begin
      evt <= '0;
    end
  endtask

  task automatic wr(input logic [ISC_ADDR_W-1:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 21'h0);
  endtask

  task automatic rdchk(input logic [ISC_ADDR_W-1:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, 21'h0);
    check(rd, exp);
  endtask

  task automatic pulse(input logic [20:0] v);
    @(posedge clk);
    evt <= isc_evt_t'(v);
    @(posedge clk);
    evt <= '0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, enter_low_power} = 4'h0;
    paddr = '0;
    pwdata = 32'h0;
    evt = '0;
    drop_count = 32'h0;
    timer_count = 16'h0005;
    rx_frame_len = 14'h0801;
    tx_free_space = 8'h00;
    tx_space_level = 8'h04;
    io_pins = 3'h0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    wr(ISC_OFF_STATUS, 32'hffff_ffff);
    rdchk(ISC_OFF_STATUS, 32'h0);
    rdchk(ISC_OFF_MASK, 32'h0);
    check({31'h0, irq_master}, 32'h0);
    for (int i = 0; i < 19; i++) begin
      pulse(EV[i]);
      rdchk(ISC_OFF_STATUS, EX[i]);
      wr(ISC_OFF_STATUS, ISC_W1C_MASK & ~EX[i]);
      rdchk(ISC_OFF_STATUS, EX[i]);
      wr(ISC_OFF_STATUS, EX[i]);
      rdchk(ISC_OFF_STATUS, 32'h0);
    end
    rx_frame_len <= 14'h0800;
    pulse(21'h000400);
    rdchk(ISC_OFF_STATUS, 32'h0);
    @(posedge clk);
    drop_count <= ISC_DROP_BEFORE_MID;
    timer_count <= ISC_TIMER_ZERO;
    @(posedge clk);
    drop_count <= ISC_DROP_MID;
    timer_count <= ISC_TIMER_WRAP;
    rdchk(ISC_OFF_STATUS, 32'h0088_0000);
    wr(ISC_OFF_STATUS, 32'h0088_0000);
    tx_free_space <= 8'h04;
    rdchk(ISC_OFF_STATUS, 32'h0);
    tx_free_space <= 8'h05;
    rdchk(ISC_OFF_STATUS, 32'h0000_0200);
    wr(ISC_OFF_STATUS, 32'h0000_0200);
    io_pins <= 3'h1;
    repeat (5) @(posedge clk);
    rdchk(ISC_OFF_STATUS, 32'h0);
    io_pins <= 3'h0;
    repeat (5) @(posedge clk);
    rdchk(ISC_OFF_STATUS, 32'h0000_0001);
    wr(ISC_OFF_IO_CFG, 32'h7);
    io_pins <= 3'h6;
    repeat (5) @(posedge clk);
    rdchk(ISC_OFF_STATUS, 32'h0000_0007);
    wr(ISC_OFF_STATUS, 32'h0000_0007);
    rdchk(ISC_OFF_STATUS, 32'h0);
    evt <= isc_evt_t'(21'h004000);
    rdchk(ISC_OFF_STATUS, 32'h0004_0000);
    wr(ISC_OFF_STATUS, 32'hffff_ffff);
    rdchk(ISC_OFF_STATUS, 32'h0004_0000);
    evt <= '0;
    // Set on the same edge as the clearing write must survive.
    pulse(21'h000200);
    apb(1'b1, ISC_OFF_STATUS, 32'h0000_4000, 21'h000200);
    rdchk(ISC_OFF_STATUS, 32'h0000_4000);
    wr(ISC_OFF_MASK, 32'h0000_4000);
    @(negedge clk);
    check({31'h0, irq_master}, 32'h1);
    check({31'h0, wake_irq}, 32'h0);
    wr(ISC_OFF_MASK, 32'h0);
    @(negedge clk);
    check({31'h0, irq_master}, 32'h0);
    rdchk(ISC_OFF_STATUS, 32'h0000_4000);
    wr(ISC_OFF_STATUS, 32'h0000_4000);
    wr(ISC_OFF_MASK, 32'h0002_0000);
    pulse(21'h002000);
    @(negedge clk);
    check({30'h0, wake_irq, irq_master}, 32'h3);
    wr(ISC_OFF_STATUS, 32'h0002_0000);
    @(negedge clk);
    check({30'h0, wake_irq, irq_master}, 32'h0);
    wr(ISC_OFF_MASK, 32'hffff_ffff);
    rdchk(ISC_OFF_MASK, ISC_IMPL_MASK);
    check({31'h0, software_event_enable}, 32'h1);
    rdchk(ISC_OFF_STATUS, 32'h8000_0000);
    wr(ISC_OFF_STATUS, 32'h8000_0000);
    rdchk(ISC_OFF_STATUS, 32'h8000_0000);
    wr(ISC_OFF_MASK, 32'h0);
    wr(ISC_OFF_STATUS, 32'h8000_0000);
    rdchk(ISC_OFF_STATUS, 32'h0);
    @(posedge clk);
    enter_low_power <= 1'b1;
    @(posedge clk);
    enter_low_power <= 1'b0;
    pulse(21'h002000);
    @(negedge clk);
    check({31'h0, low_power}, 32'h1);
    rdchk(ISC_OFF_BYTE_TEST, ISC_BYTE_TEST_VAL);
    check({31'h0, low_power}, 32'h1);
    wr(ISC_OFF_BYTE_TEST, 32'h0);
    @(negedge clk);
    check({31'h0, low_power}, 32'h0);
    rdchk(ISC_OFF_STATUS, 32'h0002_0000);
    check({31'h0, err}, 32'h0);
    rdchk(8'h70, 32'h0);
    check({31'h0, err}, 32'h1);
    print_verdict();
  end
endmodule
